//--- inc/trgpwm_params.svh
`ifndef TRGPWM_PARAMS_SVH
`define TRGPWM_PARAMS_SVH

// register byte offsets
`define TRGPWM_OFS_CTRL 6'h00
`define TRGPWM_OFS_COUNT 6'h04
`define TRGPWM_OFS_PERIOD 6'h08
`define TRGPWM_OFS_CHANGE 6'h0C
`define TRGPWM_OFS_WAIT 6'h10
`define TRGPWM_OFS_STATUS 6'h14
`define TRGPWM_OFS_MASK 6'h18
`define TRGPWM_OFS_PORT 6'h1C

// control_reg_one / control_reg_two fields, gathered in one word
`define TRGPWM_CTRL_RUN 0
`define TRGPWM_CTRL_LVL 1
`define TRGPWM_CTRL_STOP 2
`define TRGPWM_CTRL_CLR 3
`define TRGPWM_CTRL_EDGE_LO 4
`define TRGPWM_CTRL_EDGE_HI 5
`define TRGPWM_CTRL_DIV 8
`define TRGPWM_CTRL_ROLE 12
`define TRGPWM_CTRL_WMASK 16'h373F
`define TRGPWM_CTRL_RESET 16'h0000

// status and mask bits
`define TRGPWM_ST_PERIOD 0
`define TRGPWM_ST_CHANGE 1
`define TRGPWM_ST_WAIT 2
`define TRGPWM_ST_OVF 3
`define TRGPWM_ST_EXT 4
`define TRGPWM_ST_CUT 5
`define TRGPWM_ST_W 6

// port register fields
`define TRGPWM_PORT_OUT 0
`define TRGPWM_PORT_DIR 4
`define TRGPWM_PORT_IN 8

// external pin roles
`define TRGPWM_ROLE_PORT 2'h0
`define TRGPWM_ROLE_INT 2'h1
`define TRGPWM_ROLE_CUT 2'h2

// count source prescaler masks: f1, f2, f4, f8, f32
`define TRGPWM_DIV_F1 5'h00
`define TRGPWM_DIV_F2 5'h01
`define TRGPWM_DIV_F4 5'h03
`define TRGPWM_DIV_F8 5'h07
`define TRGPWM_DIV_F32 5'h1F
`endif

//--- inc/trgpwm_pkg.sv
package trgpwm_pkg;
  typedef enum logic [2:0] {
    TRGPWM_IDLE = 3'b001,
    TRGPWM_ARMED = 3'b010,
    TRGPWM_RUN = 3'b100
  } trgpwm_state_e;
  typedef logic [1:0] trgpwm_htrans_t;
endpackage : trgpwm_pkg

//--- inc/trgpwm_pin_if.sv
interface trgpwm_pin_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] lvl;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;
  modport sync (input raw, output lvl, output rise, output fall);
  modport user (output raw, input lvl, input rise, input fall);
endinterface : trgpwm_pin_if

//--- rtl/trgpwm_sync.sv
module trgpwm_sync #(
  parameter int WIDTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  trgpwm_pin_if.sync pins
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } trgpwm_sync_s;

  trgpwm_sync_s r_reg;
  trgpwm_sync_s r_next;

  if (WIDTH < 1) begin : g_bad_width
    $error("trgpwm_sync needs at least one input");
  end

  always_comb begin
    r_next = r_reg;
    r_next.s1 = pins.raw;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.rise = '0;
    r_next.fall = '0;
    for (int i = 0; i < WIDTH; i++) begin
      // a level counts only once stages two and three agree
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.lvl[i] = r_reg.s3[i];
        r_next.rise[i] = r_reg.s3[i] & ~r_reg.lvl[i];
        r_next.fall[i] = ~r_reg.s3[i] & r_reg.lvl[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pins.lvl = r_reg.lvl;
  assign pins.rise = r_reg.rise;
  assign pins.fall = r_reg.fall;
endmodule : trgpwm_sync

//--- rtl/trgpwm_top.sv
// Our own choices: the register addresses and the AHB-Lite register port.
`include "trgpwm_params.svh"
module trgpwm_top import trgpwm_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire trgpwm_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic chan_a_pin_i,
  output logic chan_a_pin_o,
  output logic chan_a_pin_oe,
  output logic pwm_out_pin_o,
  output logic pwm_out_pin_oe,
  input wire logic chan_c_pin_i,
  output logic chan_c_pin_o,
  output logic chan_c_pin_oe,
  input wire logic chan_d_pin_i,
  output logic chan_d_pin_o,
  output logic chan_d_pin_oe,
  input wire logic ext_int_pin_i,
  output logic irq
);
  typedef struct packed {
    trgpwm_state_e state;
    logic [15:0] ctrl;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] change;
    logic [CNT_W-1:0] waitc;
    logic [`TRGPWM_ST_W-1:0] status;
    logic [`TRGPWM_ST_W-1:0] mask;
    logic [2:0] port_out;
    logic [2:0] port_dir;
    logic [4:0] div_cnt;
    logic wr_pend;
    logic rd_pend;
    logic [5:0] addr;
    logic [31:0] hrdata;
    logic hready;
    logic irq;
    logic pwm_out;
    logic pwm_oe;
    logic [2:0] pin_o;
    logic [2:0] pin_oe;
  } trgpwm_top_s;

  trgpwm_top_s r_reg;
  trgpwm_top_s r_next;

  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
    $error("trgpwm_top counter width must be 2 to 32");
  end

  // lane 0 chan_a, 1 chan_c, 2 chan_d, 3 external pin
  trgpwm_pin_if #(.WIDTH(4)) pin_bus ();
  assign pin_bus.raw = {ext_int_pin_i, chan_d_pin_i, chan_c_pin_i, chan_a_pin_i};

  trgpwm_sync #(.WIDTH(4)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins(pin_bus.sync)
  );

  always_comb begin
    logic lvl_sel;
    logic stop_m;
    logic clr_m;
    logic [1:0] edge_sel;
    logic [1:0] role;
    logic [4:0] div_mask;
    logic tick;
    logic trig;
    logic active;
    logic cut;
    logic [`TRGPWM_ST_W-1:0] set_ev;
    logic [31:0] rdat;
    logic [15:0] new_ctrl;
    r_next = r_reg;
    lvl_sel = r_reg.ctrl[`TRGPWM_CTRL_LVL];
    stop_m = r_reg.ctrl[`TRGPWM_CTRL_STOP];
    clr_m = r_reg.ctrl[`TRGPWM_CTRL_CLR];
    edge_sel = r_reg.ctrl[`TRGPWM_CTRL_EDGE_HI:`TRGPWM_CTRL_EDGE_LO];
    role = r_reg.ctrl[`TRGPWM_CTRL_ROLE+1:`TRGPWM_CTRL_ROLE];
    set_ev = '0;
    rdat = 32'h00000000;
    new_ctrl = r_reg.ctrl;
    active = r_reg.pwm_out;
    div_mask = `TRGPWM_DIV_F1;
    tick = 1'b0;
    trig = 1'b0;
    cut = 1'b0;

    // count source enable from a free-running divider
    case (r_reg.ctrl[`TRGPWM_CTRL_DIV+2:`TRGPWM_CTRL_DIV])
      3'h1: div_mask = `TRGPWM_DIV_F2;
      3'h2: div_mask = `TRGPWM_DIV_F4;
      3'h3: div_mask = `TRGPWM_DIV_F8;
      3'h4: div_mask = `TRGPWM_DIV_F32;
      default: div_mask = `TRGPWM_DIV_F1;
    endcase
    r_next.div_cnt = 5'(r_reg.div_cnt + 5'h01);
    tick = ((r_reg.div_cnt & div_mask) == div_mask);

    trig = (edge_sel[0] & pin_bus.rise[0]) | (edge_sel[1] & pin_bus.fall[0]);

    case (r_reg.state)
      TRGPWM_ARMED: begin
        if (trig) begin
          r_next.state = TRGPWM_RUN;
        end
      end
      TRGPWM_RUN: begin
        if (tick) begin
          if (r_reg.count == r_reg.period) begin
            set_ev[`TRGPWM_ST_PERIOD] = 1'b1;
          end
          if (r_reg.count == r_reg.change) begin
            set_ev[`TRGPWM_ST_CHANGE] = 1'b1;
          end
          if (r_reg.count == r_reg.waitc) begin
            set_ev[`TRGPWM_ST_WAIT] = 1'b1;
          end
          if (set_ev[`TRGPWM_ST_WAIT]) begin
            active = ~lvl_sel;
          end
          if (set_ev[`TRGPWM_ST_CHANGE]) begin
            active = lvl_sel;
          end
          if (set_ev[`TRGPWM_ST_PERIOD] && stop_m) begin
            active = lvl_sel;
            r_next.count = clr_m ? '0 : r_reg.count;
            if (edge_sel != 2'h0) begin
              r_next.state = TRGPWM_ARMED;
            end else begin
              r_next.state = TRGPWM_IDLE;
              new_ctrl[`TRGPWM_CTRL_RUN] = 1'b0;
            end
          end else if (set_ev[`TRGPWM_ST_PERIOD] && clr_m) begin
            r_next.count = '0;
          end else begin
            r_next.count = CNT_W'(r_reg.count + 1'b1);
            if (r_reg.count == {CNT_W{1'b1}}) begin
              set_ev[`TRGPWM_ST_OVF] = 1'b1;
            end
          end
        end
      end
      default: begin
        r_next.state = TRGPWM_IDLE;
      end
    endcase

    // external pin as interrupt or cutoff
    cut = (role == `TRGPWM_ROLE_CUT) & ~pin_bus.lvl[3];
    if (role == `TRGPWM_ROLE_INT && pin_bus.fall[3]) begin
      set_ev[`TRGPWM_ST_EXT] = 1'b1;
    end
    if (role == `TRGPWM_ROLE_CUT && pin_bus.fall[3]) begin
      set_ev[`TRGPWM_ST_CUT] = 1'b1;
    end

    // bus data phase of a write
    if (r_reg.wr_pend) begin
      case (r_reg.addr)
        `TRGPWM_OFS_CTRL: begin
          new_ctrl = hwdata[15:0] & `TRGPWM_CTRL_WMASK;
          if (hwdata[`TRGPWM_CTRL_RUN] && !r_reg.ctrl[`TRGPWM_CTRL_RUN]) begin
            if (hwdata[`TRGPWM_CTRL_EDGE_HI:`TRGPWM_CTRL_EDGE_LO] == 2'h0 || !hwdata[`TRGPWM_CTRL_STOP]) begin
              r_next.state = TRGPWM_RUN;
            end else begin
              r_next.state = TRGPWM_ARMED;
            end
          end else if (!hwdata[`TRGPWM_CTRL_RUN]) begin
            r_next.state = TRGPWM_IDLE;
          end
        end
        `TRGPWM_OFS_COUNT: r_next.count = hwdata[CNT_W-1:0];
        `TRGPWM_OFS_PERIOD: r_next.period = hwdata[CNT_W-1:0];
        `TRGPWM_OFS_CHANGE: r_next.change = hwdata[CNT_W-1:0];
        `TRGPWM_OFS_WAIT: r_next.waitc = hwdata[CNT_W-1:0];
        `TRGPWM_OFS_MASK: r_next.mask = hwdata[`TRGPWM_ST_W-1:0];
        `TRGPWM_OFS_PORT: begin
          r_next.port_out = hwdata[`TRGPWM_PORT_OUT+2:`TRGPWM_PORT_OUT];
          r_next.port_dir = hwdata[`TRGPWM_PORT_DIR+2:`TRGPWM_PORT_DIR];
        end
        default: begin
        end
      endcase
    end
    r_next.ctrl = new_ctrl;

    // hardware set beats a same-cycle write-one clear
    r_next.status = r_reg.status | set_ev;
    if (r_reg.wr_pend && r_reg.addr == `TRGPWM_OFS_STATUS) begin
      r_next.status = (r_reg.status & ~hwdata[`TRGPWM_ST_W-1:0]) | set_ev;
    end
    r_next.irq = |(r_next.status & r_next.mask);

    if (r_next.state == TRGPWM_IDLE) begin
      active = new_ctrl[`TRGPWM_CTRL_LVL];
    end
    r_next.pwm_out = active;
    r_next.pwm_oe = ~cut;

    // channel A yields to the trigger role
    r_next.pin_o = r_next.port_out;
    r_next.pin_oe = r_next.port_dir;
    if (new_ctrl[`TRGPWM_CTRL_EDGE_HI:`TRGPWM_CTRL_EDGE_LO] != 2'h0) begin
      r_next.pin_oe[0] = 1'b0;
    end

    // read data, one wait state so a prior write is seen
    case (r_reg.addr)
      `TRGPWM_OFS_CTRL: rdat = {16'h0000, r_reg.ctrl};
      `TRGPWM_OFS_COUNT: rdat = 32'(r_reg.count);
      `TRGPWM_OFS_PERIOD: rdat = 32'(r_reg.period);
      `TRGPWM_OFS_CHANGE: rdat = 32'(r_reg.change);
      `TRGPWM_OFS_WAIT: rdat = 32'(r_reg.waitc);
      `TRGPWM_OFS_STATUS: rdat = 32'(r_reg.status);
      `TRGPWM_OFS_MASK: rdat = 32'(r_reg.mask);
      `TRGPWM_OFS_PORT: rdat = {20'h00000, pin_bus.lvl, 1'b0, r_reg.port_dir, 1'b0, r_reg.port_out};
      default: rdat = 32'h00000000;
    endcase

    r_next.wr_pend = 1'b0;
    if (r_reg.rd_pend) begin
      r_next.rd_pend = 1'b0;
      r_next.hrdata = rdat;
      r_next.hready = 1'b1;
    end
    if (hsel && htrans[1] && hready && r_reg.hready) begin
      r_next.addr = {haddr[5:2], 2'h0};
      r_next.wr_pend = hwrite;
      r_next.rd_pend = ~hwrite;
      r_next.hready = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg.state <= TRGPWM_IDLE;
      r_reg.ctrl <= `TRGPWM_CTRL_RESET;
      r_reg.count <= '0;
      r_reg.period <= '1;
      r_reg.change <= '1;
      r_reg.waitc <= '1;
      r_reg.status <= '0;
      r_reg.mask <= '0;
      r_reg.port_out <= 3'h0;
      r_reg.port_dir <= 3'h0;
      r_reg.div_cnt <= 5'h00;
      r_reg.wr_pend <= 1'b0;
      r_reg.rd_pend <= 1'b0;
      r_reg.addr <= 6'h00;
      r_reg.hrdata <= 32'h00000000;
      r_reg.hready <= 1'b1;
      r_reg.irq <= 1'b0;
      r_reg.pwm_out <= 1'b0;
      r_reg.pwm_oe <= 1'b1;
      r_reg.pin_o <= 3'h0;
      r_reg.pin_oe <= 3'h0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = r_reg.hready;
  assign hresp = 1'b0;
  assign hrdata = r_reg.hrdata;
  assign irq = r_reg.irq;
  assign pwm_out_pin_o = r_reg.pwm_out;
  assign pwm_out_pin_oe = r_reg.pwm_oe;
  assign chan_a_pin_o = r_reg.pin_o[0];
  assign chan_a_pin_oe = r_reg.pin_oe[0];
  assign chan_c_pin_o = r_reg.pin_o[1];
  assign chan_c_pin_oe = r_reg.pin_oe[1];
  assign chan_d_pin_o = r_reg.pin_o[2];
  assign chan_d_pin_oe = r_reg.pin_oe[2];
endmodule : trgpwm_top

//--- testbench/trgpwm_props.sv
`include "trgpwm_params.svh"
module trgpwm_props import trgpwm_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire trgpwm_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic chan_a_pin_oe,
  input wire logic pwm_out_pin_o,
  input wire logic pwm_out_pin_oe,
  input wire logic ext_int_pin_i,
  input wire logic irq
);
  logic wr_ph_reg;
  logic [5:0] wa_reg;
  logic [15:0] ctl_reg;
  logic [15:0] msk_reg;
  wire take = hsel && htrans[1] && hready && hreadyout;
  // shadow of control and mask, seen from bus writes only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_reg <= 1'b0;
      wa_reg <= 6'h00;
      ctl_reg <= 16'h0000;
      msk_reg <= 16'h0000;
    end else begin
      wr_ph_reg <= take && hwrite;
      wa_reg <= take ? haddr[5:0] : wa_reg;
      if (wr_ph_reg && wa_reg == `TRGPWM_OFS_CTRL) ctl_reg <= hwdata[15:0] & `TRGPWM_CTRL_WMASK;
      if (wr_ph_reg && wa_reg == `TRGPWM_OFS_MASK) msk_reg <= hwdata[15:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_take;
    take && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_READ_ONE_WAIT: assert property (rd_take |=> one_wait)
    else $error("read answer timing wrong");
  AST_WRITE_NO_WAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_HRDATA_HOLD: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside a read");
  AST_CHAN_A_TRIG: assert property (ctl_reg[5:4] != 2'h0 && $stable(ctl_reg) |-> !chan_a_pin_oe)
    else $error("trigger pin driven");
  AST_IRQ_MASKED: assert property (msk_reg[5:0] == 6'h00 && $stable(msk_reg) |-> !irq)
    else $error("irq with all masked");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_ph_reg))
    else $error("irq dropped without a write");
  AST_CUTOFF: assert property ((ctl_reg[13:12] == 2'h2 && !ext_int_pin_i)[*8] |-> !pwm_out_pin_oe)
    else $error("pulse pin not cut off");
  AST_IDLE_LEVEL: assert property ((!ctl_reg[0] && $stable(ctl_reg))[*3] |-> pwm_out_pin_o == ctl_reg[1])
    else $error("idle level wrong");
endmodule : trgpwm_props
bind trgpwm_top trgpwm_props trgpwm_props_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hrdata, .chan_a_pin_oe, .pwm_out_pin_o, .pwm_out_pin_oe, .ext_int_pin_i, .irq);

//--- testbench/trgpwm_trig_src.sv
module trgpwm_trig_src #(
  parameter int LAG = 2
) (
  input wire logic hclk,
  input wire logic trig_cmd,
  input wire logic ext_cmd,
  output logic trig_pin,
  output logic ext_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LAG-1:0] t_dly = '0;
  logic [LAG-1:0] e_dly = '1;
  // slow source: pins follow commands late
  always @(posedge hclk) begin
    t_dly <= {t_dly[LAG-2:0], trig_cmd};
    e_dly <= {e_dly[LAG-2:0], ext_cmd};
  end
  assign trig_pin = t_dly[LAG-1];
  assign ext_pin = e_dly[LAG-1];
endmodule : trgpwm_trig_src

//--- testbench/test_triggered_one_shot_pwm.sv
`include "trgpwm_params.svh"
module test_triggered_one_shot_pwm;
  import trgpwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, trig = 0, ext = 1;
  logic [31:0] haddr = 0, hwdata = 0, rnd = 32'h8E24, hrdata;
  trgpwm_htrans_t htrans = 2'h0;
  logic hreadyout, irq, pwm_out_pin_o, chan_a_pin_i, ext_int_pin_i;
  logic rd_pend = 0, armed = 0, irq_look = 0, lvl_sh = 0;
  logic pin_look = 0, pc = 0, pd = 0, hresp, chan_a_pin_o, chan_a_pin_oe;
  logic chan_c_pin_o, chan_c_pin_oe, chan_d_pin_o, chan_d_pin_oe;
  logic [15:0] p, n;
  logic [31:0] notes[$];
  int bad_count = 0, num_checks = 0, width = 0;
  logic [5:0] ofs[8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h20};
  logic [31:0] rv[8] = '{0, 0, 32'hFFFF, 32'hFFFF, 32'hFFFF, 0, 0, 0};
  always #20 hclk = ~hclk;
  trgpwm_trig_src #(.LAG(3)) trgpwm_trig_src_i (.hclk, .trig_cmd(trig), .ext_cmd(ext),
    .trig_pin(chan_a_pin_i), .ext_pin(ext_int_pin_i));
  trgpwm_top trgpwm_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .chan_a_pin_i, .chan_a_pin_o, .chan_a_pin_oe,
    .pwm_out_pin_o, .pwm_out_pin_oe(), .chan_c_pin_i(pc), .chan_c_pin_o, .chan_c_pin_oe,
    .chan_d_pin_i(pd), .chan_d_pin_o, .chan_d_pin_oe, .ext_int_pin_i, .irq);
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic cmp(string w, logic [31:0] g);
    logic [31:0] e;
    e = notes.pop_front();
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask : cmp
  task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {26'h0, a};
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) begin bad_count++; report_and_stop(); end
  endtask : bus
  task automatic wr(logic [5:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(logic [5:0] a, logic [31:0] e);
    notes.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic look(logic e);
    repeat (2) @(posedge hclk);
    notes.push_back({31'h0, e});
    irq_look <= 1'b1;
    @(posedge hclk);
  endtask : look
  task automatic look_pins(logic [31:0] e);
    @(posedge hclk);
    notes.push_back(e);
    pin_look <= 1'b1;
    @(posedge hclk);
  endtask : look_pins
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) cmp("hrdata", hrdata);
    rd_pend <= (hsel && htrans[1] && !hwrite && hreadyout) || (rd_pend && hreadyout !== 1'b1);
    if (irq_look) begin cmp("irq", {31'h0, irq}); irq_look <= 1'b0; end
    if (pin_look) begin
      cmp("pins", {25'h0, hresp, chan_d_pin_oe, chan_c_pin_oe, chan_a_pin_oe,
        chan_d_pin_o, chan_c_pin_o, chan_a_pin_o});
      pin_look <= 1'b0;
    end
    if (armed && pwm_out_pin_o === ~lvl_sh) width <= width + 1;
    else if (armed && width > 0) begin cmp("pulse width", 32'(width)); width <= 0; armed <= 1'b0; end
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ofs[i]) rd(ofs[i], rv[i]);
    rnd = xs(rnd);
    wr(`TRGPWM_OFS_COUNT, rnd);
    rd(`TRGPWM_OFS_COUNT, rnd & 32'hFFFF);
    for (int c = 0; c < 2; c++) begin
      rnd = xs(rnd);
      p = 16'(rnd[3:0]) + 16'h2;
      n = p + 16'(rnd[7:4]) + 16'h2;
      wr(`TRGPWM_OFS_PERIOD, n + 3);
      wr(`TRGPWM_OFS_CHANGE, n);
      wr(`TRGPWM_OFS_WAIT, p);
      wr(`TRGPWM_OFS_COUNT, 0);
      wr(`TRGPWM_OFS_STATUS, 32'h3F);
      wr(`TRGPWM_OFS_CTRL, 32'h4 | c << 3);
      notes.push_back(n - p);
      armed <= 1'b1;
      wr(`TRGPWM_OFS_CTRL, 32'h5 | c << 3);
      repeat (n + 13) @(posedge hclk);
      rd(`TRGPWM_OFS_COUNT, c ? 0 : n + 3);
      rd(`TRGPWM_OFS_STATUS, 32'h7);
    end
    wr(`TRGPWM_OFS_CTRL, 0);
    wr(`TRGPWM_OFS_PERIOD, 32'h100);
    wr(`TRGPWM_OFS_CHANGE, 32'h80);
    wr(`TRGPWM_OFS_WAIT, 32'h40);
    wr(`TRGPWM_OFS_STATUS, 32'h3F);
    wr(`TRGPWM_OFS_MASK, 32'h8);
    wr(`TRGPWM_OFS_COUNT, 32'hFFFE);
    wr(`TRGPWM_OFS_CTRL, 1);
    repeat (6) @(posedge hclk);
    wr(`TRGPWM_OFS_CTRL, 0);
    rd(`TRGPWM_OFS_STATUS, 32'h8);
    look(1'b1);
    wr(`TRGPWM_OFS_MASK, 0);
    look(1'b0);
    wr(`TRGPWM_OFS_MASK, 32'h8);
    look(1'b1);
    wr(`TRGPWM_OFS_STATUS, 32'h8);
    look(1'b0);
    wr(`TRGPWM_OFS_PERIOD, 32'h30);
    wr(`TRGPWM_OFS_CHANGE, 32'h20);
    wr(`TRGPWM_OFS_WAIT, 32'h8);
    wr(`TRGPWM_OFS_PORT, 32'h71);
    lvl_sh = 1'b1;
    for (int e = 1; e < 4; e++) begin
      trig <= (e == 1);
      wr(`TRGPWM_OFS_CTRL, 32'h6 | e << 4);
      wr(`TRGPWM_OFS_COUNT, 0);
      repeat (8) @(posedge hclk);
      wr(`TRGPWM_OFS_CTRL, 32'h7 | e << 4);
      if (e == 3) begin notes.push_back(32'h18); armed <= 1'b1; end
      trig <= (e != 1);
      repeat (10) @(posedge hclk);
      if (e != 3) begin
        rd(`TRGPWM_OFS_COUNT, 0);
        notes.push_back(32'h18);
        armed <= 1'b1;
        trig <= (e == 1);
      end
      repeat (60) @(posedge hclk);
      rd(`TRGPWM_OFS_COUNT, 32'h30);
      wr(`TRGPWM_OFS_CTRL, 32'h6 | e << 4);
    end
    look_pins(32'h31);
    {pd, pc} <= rnd[9:8];
    wr(`TRGPWM_OFS_STATUS, 32'h3F);
    wr(`TRGPWM_OFS_CTRL, 32'h2000);
    ext <= 1'b0;
    repeat (12) @(posedge hclk);
    rd(`TRGPWM_OFS_STATUS, 32'h20);
    ext <= 1'b1;
    wr(`TRGPWM_OFS_CTRL, 32'h1000);
    wr(`TRGPWM_OFS_STATUS, 32'h3F);
    ext <= 1'b0;
    repeat (12) @(posedge hclk);
    rd(`TRGPWM_OFS_STATUS, 32'h10);
    wr(`TRGPWM_OFS_PORT, 32'h77);
    rd(`TRGPWM_OFS_PORT, 32'h77 | {ext, pd, pc, trig} << 8);
    look_pins(32'h3F);
    @(posedge hclk);
    if (notes.size() != 0) begin
      bad_count++;
      $display("unexpected notes left expected 0 seen %0d", notes.size());
    end
    report_and_stop();
  end
endmodule : test_triggered_one_shot_pwm
